// file: rtl/anx_input_sync.sv
// two-flop synchronisers for the link-side status lines
module anx_input_sync (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [5:0]  raw_in,
    anx_sync_if.src          sync
);
    logic [5:0] meta_reg;
    logic [5:0] stable_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg   <= 6'h00;
            stable_reg <= 6'h00;
        end else begin
            meta_reg   <= raw_in;
            stable_reg <= meta_reg;
        end
    end

    assign sync.link10_ok       = stable_reg[0];
    assign sync.link100_ok      = stable_reg[1];
    assign sync.link_lost       = stable_reg[2];
    assign sync.partner_an_able = stable_reg[3];
    assign sync.page_valid      = stable_reg[4];
    assign sync.page_sent       = stable_reg[5];
endmodule : anx_input_sync

// file: rtl/anx_params.svh
// register offsets, field positions, reset values for the expansion and next-page block
`ifndef ANX_PARAMS_SVH
`define ANX_PARAMS_SVH
`define OFF_EXPANSION      8'h18
`define OFF_NP_TRANSMIT    8'h1c
`define OFF_CONFIG         8'h70
`define OFF_EVENT_STATUS   8'h80
`define OFF_EVENT_MASK     8'h84
`define OFF_PARTNER_PAGE   8'h88
`define IDX_EXPANSION      8'h06
`define IDX_NP_TRANSMIT    8'h07
`define IDX_CONFIG         8'h1c
`define BIT_PD_FAULT       4
`define BIT_LP_NP_ABLE     3
`define BIT_NP_ABLE        2
`define BIT_PAGE_RCVD      1
`define BIT_LP_AN_ABLE     0
`define BIT_NP_MORE        15
`define BIT_NP_ACK         14
`define BIT_NP_MSG         13
`define BIT_NP_ACK2        12
`define BIT_NP_TOGGLE      11
`define BIT_CFG_LEGACY     0
`define BIT_CFG_NP_EN      1
`define NP_CODE_RESET      11'h001
`define NP_MSG_RESET       1'b1
`define CFG_RESET          2'h0
`define EVT_PD_FAULT       0
`define EVT_PAGE_RCVD      1
`define EVT_TX_DONE        2
`endif

// file: rtl/anx_pkg.sv
// types shared by the expansion and next-page block
package anx_pkg;
    typedef enum logic [2:0] {
        NP_IDLE  = 3'b001,
        NP_BASE  = 3'b010,
        NP_NEXT  = 3'b100
    } np_state_t;
    typedef logic [15:0] page_t;
endpackage : anx_pkg

// file: rtl/anx_regs.sv
// auto-negotiation expansion and next-page transmit registers behind an axi4-lite slave
`include "anx_params.svh"
module anx_regs
    import anx_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        link10_ok,
    input  wire logic        link100_ok,
    input  wire logic        link_lost,
    input  wire logic        partner_an_able,
    input  wire logic        page_valid,
    input  wire logic [15:0] rx_page,
    input  wire logic        page_sent,
    output logic [15:0]      tx_page,
    output logic             np_exchange_en,
    output logic             irq
);
    anx_sync_if sync ();
    anx_input_sync u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .raw_in  ({page_sent, page_valid, partner_an_able, link_lost, link100_ok, link10_ok}),
        .sync    (sync)
    );
    // rx_page is quasi-static: sampled two cycles after page_valid rises, already settled
    logic [15:0] rx_meta_reg;
    logic [15:0] rx_page_reg;
    logic [15:0] lp_page_reg;
    logic        pv_d_reg;
    logic        ps_d_reg;
    logic        fault_d_reg;
    logic        pd_fault_reg;
    logic        page_rcvd_reg;
    logic        lp_np_able_reg;
    logic        lp_an_able_reg;
    logic        np_more_reg;
    logic        np_ack_reg;
    logic        np_msg_reg;
    logic        np_ack2_reg;
    logic        np_toggle_reg;
    logic [10:0] np_code_reg;
    logic        legacy_reg;
    logic        np_en_reg;
    logic [2:0]  evt_status_reg;
    logic [2:0]  evt_mask_reg;
    np_state_t   np_state_reg;
    logic        aw_hold_reg;
    logic        w_hold_reg;
    logic [7:0]  aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                           input logic [31:0] data,
                                           input logic [3:0]  strb);
        merge16 = {strb[1] ? data[15:8] : old_v[15:8], strb[0] ? data[7:0] : old_v[7:0]};
    endfunction : merge16
    function automatic logic mapped(input logic [7:0] addr);
        mapped = (addr == `OFF_EXPANSION) || (addr == `OFF_NP_TRANSMIT) ||
                 (addr == `OFF_CONFIG) || (addr == `OFF_EVENT_STATUS) ||
                 (addr == `OFF_EVENT_MASK) || (addr == `OFF_PARTNER_PAGE);
    endfunction : mapped
    logic        pv_rise;
    logic        ps_rise;
    logic        fault_now;
    logic        fault_rise;
    logic        wr_fire;
    logic        rd_fire;
    logic [15:0] exp_word;
    logic [15:0] np_word;
    logic [15:0] np_new;
    assign pv_rise    = sync.page_valid & ~pv_d_reg;
    assign ps_rise    = sync.page_sent & ~ps_d_reg;
    assign fault_now  = (sync.link10_ok & sync.link100_ok) | sync.link_lost;
    assign fault_rise = fault_now & ~fault_d_reg;
    assign wr_fire    = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
    assign rd_fire    = s_axi_arvalid & s_axi_arready;
    assign np_new     = merge16(np_word, w_data_reg, w_strb_reg);
    assign np_word    = {np_more_reg, np_ack_reg, np_msg_reg, np_ack2_reg, np_toggle_reg,
                         np_code_reg};
    always_comb begin
        exp_word = 16'h0000;
        exp_word[`BIT_PD_FAULT]   = pd_fault_reg;
        exp_word[`BIT_LP_NP_ABLE] = lp_np_able_reg;
        exp_word[`BIT_NP_ABLE]    = ~legacy_reg;
        exp_word[`BIT_PAGE_RCVD]  = page_rcvd_reg;
        exp_word[`BIT_LP_AN_ABLE] = lp_an_able_reg;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pv_d_reg    <= 1'b0;
            ps_d_reg    <= 1'b0;
            fault_d_reg <= 1'b0;
            rx_meta_reg <= 16'h0000;
            rx_page_reg <= 16'h0000;
            lp_page_reg <= 16'h0000;
        end else begin
            pv_d_reg    <= sync.page_valid;
            ps_d_reg    <= sync.page_sent;
            fault_d_reg <= fault_now;
            rx_meta_reg <= rx_page;
            rx_page_reg <= rx_meta_reg;
            lp_page_reg <= pv_rise ? rx_page_reg : lp_page_reg;
        end
    end
    // self-clearing bits: a new event in the read cycle wins over the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pd_fault_reg  <= 1'b0;
            page_rcvd_reg <= 1'b0;
        end else begin
            if (fault_rise) begin
                pd_fault_reg <= 1'b1;
            end else if (rd_fire && s_axi_araddr == `OFF_EXPANSION) begin
                pd_fault_reg <= 1'b0;
            end
            if (pv_rise) begin
                page_rcvd_reg <= 1'b1;
            end else if (rd_fire && s_axi_araddr == `OFF_EXPANSION) begin
                page_rcvd_reg <= 1'b0;
            end
        end
    end
    // partner next-page ability comes from the base page: bit 15 is its next-page flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lp_np_able_reg <= 1'b0;
            lp_an_able_reg <= 1'b0;
        end else begin
            lp_an_able_reg <= sync.partner_an_able;
            if (!sync.partner_an_able) begin
                lp_np_able_reg <= 1'b0;
            end else if (pv_rise && np_state_reg != NP_NEXT) begin
                lp_np_able_reg <= rx_page_reg[15];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            np_state_reg <= NP_IDLE;
        end else begin
            unique case (np_state_reg)
                NP_IDLE: begin
                    if (sync.partner_an_able) begin
                        np_state_reg <= NP_BASE;
                    end
                end
                NP_BASE: begin
                    if (!sync.partner_an_able) begin
                        np_state_reg <= NP_IDLE;
                    end else if (pv_rise) begin
                        np_state_reg <= NP_NEXT;
                    end
                end
                NP_NEXT: begin
                    if (!sync.partner_an_able) begin
                        np_state_reg <= NP_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            np_ack_reg <= 1'b0;
        end else if (np_state_reg == NP_IDLE) begin
            np_ack_reg <= 1'b0;
        end else if (pv_rise) begin
            np_ack_reg <= 1'b1;
        end
    end

    // toggle per next page sent; first next page starts at 0
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            np_toggle_reg <= 1'b0;
        end else if (np_state_reg != NP_NEXT) begin
            np_toggle_reg <= 1'b0;
        end else if (ps_rise && np_en_reg && !legacy_reg) begin
            np_toggle_reg <= ~np_toggle_reg;
        end
    end

    // writable next-page fields
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            np_more_reg <= 1'b0;
            np_msg_reg  <= `NP_MSG_RESET;
            np_ack2_reg <= 1'b0;
            np_code_reg <= `NP_CODE_RESET;
        end else if (wr_fire && aw_addr_reg == `OFF_NP_TRANSMIT && !legacy_reg) begin
            np_more_reg <= np_new[`BIT_NP_MORE];
            np_msg_reg  <= np_new[`BIT_NP_MSG];
            np_ack2_reg <= np_new[`BIT_NP_ACK2];
            np_code_reg <= np_new[10:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {np_en_reg, legacy_reg} <= `CFG_RESET;
            evt_mask_reg            <= 3'h0;
        end else if (wr_fire && w_strb_reg[0]) begin
            if (aw_addr_reg == `OFF_CONFIG) begin
                legacy_reg <= w_data_reg[`BIT_CFG_LEGACY];
                np_en_reg  <= w_data_reg[`BIT_CFG_NP_EN];
            end
            if (aw_addr_reg == `OFF_EVENT_MASK) begin
                evt_mask_reg <= w_data_reg[2:0];
            end
        end
    end

    // sticky events, write one to clear; set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_status_reg <= 3'h0;
        end else begin
            evt_status_reg <= (evt_status_reg &
                ~((wr_fire && aw_addr_reg == `OFF_EVENT_STATUS && w_strb_reg[0]) ?
                  w_data_reg[2:0] : 3'h0)) |
                {ps_rise, pv_rise, fault_rise};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(evt_status_reg & evt_mask_reg);
        end
    end

    // exchange gated by enable and legacy mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            np_exchange_en <= 1'b0;
            tx_page        <= 16'h0000;
        end else begin
            np_exchange_en <= np_en_reg & ~legacy_reg & lp_np_able_reg;
            tx_page        <= np_word;
        end
    end

    // write channel: address and data accepted independently
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg  <= 1'b0;
            w_hold_reg   <= 1'b0;
            aw_addr_reg  <= 8'h00;
            w_data_reg   <= 32'h0000_0000;
            w_strb_reg   <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_hold_reg  <= 1'b0;
                w_hold_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(aw_addr_reg) ? 2'b00 : 2'b10;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= ~aw_hold_reg & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
            s_axi_wready  <= ~w_hold_reg & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
        end
    end

    // read channel: one read in flight, arready drops while rvalid stands
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'b00;
        end else begin
            if (rd_fire) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
                unique case (s_axi_araddr)
                    `OFF_EXPANSION:    s_axi_rdata <= {16'h0000, exp_word};
                    `OFF_NP_TRANSMIT:  s_axi_rdata <= {16'h0000, np_word};
                    `OFF_CONFIG:       s_axi_rdata <= {30'h0, np_en_reg, legacy_reg};
                    `OFF_EVENT_STATUS: s_axi_rdata <= {29'h0, evt_status_reg};
                    `OFF_EVENT_MASK:   s_axi_rdata <= {29'h0, evt_mask_reg};
                    `OFF_PARTNER_PAGE: s_axi_rdata <= {16'h0000, lp_page_reg};
                    default:           s_axi_rdata <= 32'h0000_0000;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end else if (!s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule : anx_regs

// file: rtl/anx_sync_if.sv
// synchronised link-side event lines passed from the input stage to the register bank
interface anx_sync_if;
    logic link10_ok;
    logic link100_ok;
    logic link_lost;
    logic partner_an_able;
    logic page_valid;
    logic page_sent;
    modport src (output link10_ok, link100_ok, link_lost, partner_an_able, page_valid, page_sent);
    modport dst (input  link10_ok, link100_ok, link_lost, partner_an_able, page_valid, page_sent);
endinterface : anx_sync_if

// file: testbench/anx_regs_asserts.sv
// port-level checks on the expansion and next-page register bank
`include "anx_params.svh"
module anx_regs_asserts (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        partner_an_able,
    input wire logic [15:0] tx_page,
    input wire logic        np_exchange_en
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_b_stand;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_stand: assert property (p_b_stand)
        else $error("write response dropped early");

    property p_r_stand;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_stand: assert property (p_r_stand)
        else $error("read data dropped early");

    property p_rd_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_rd_lat: assert property (p_rd_lat)
        else $error("read answer not one cycle after address");

    property p_wr_lat;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_wr_lat: assert property (p_wr_lat)
        else $error("write response late");

    property p_b_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_b_block: assert property (p_b_block)
        else $error("write taken while response pending");

    property p_rsvd_zero;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `OFF_EXPANSION
            |=> s_axi_rdata[31:5] == 27'h0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("reserved expansion bits not zero");

    property p_unmapped;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h40
            |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not refused");

    property p_tx_reset;
        $rose(aresetn) |-> ##[0:2] tx_page == 16'h2001;
    endproperty
    a_tx_reset: assert property (p_tx_reset)
        else $error("next-page word reset value wrong");

    property p_np_en;
        !partner_an_able [*6] |-> !np_exchange_en;
    endproperty
    a_np_en: assert property (p_np_en)
        else $error("exchange enabled without partner");
endmodule : anx_regs_asserts

bind anx_regs anx_regs_asserts chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .partner_an_able, .tx_page, .np_exchange_en);

// file: testbench/autoneg_expansion_nextpage_regs_tb.sv
// self-checking bench for the expansion and next-page register bank
`include "anx_params.svh"
module autoneg_expansion_nextpage_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, link10_ok, link100_ok, link_lost, partner_an_able;
    logic        page_valid, page_sent, np_exchange_en, irq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [15:0] rx_page, tx_page;
    int          n_errors = 0;
    int          total_checks = 0;

    anx_regs dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link10_ok, .link100_ok, .link_lost,
        .partner_an_able, .page_valid, .rx_page, .page_sent, .tx_page, .np_exchange_en, .irq);
    link_partner_model lp_u (.aclk, .link10_ok, .link100_ok, .link_lost, .partner_an_able,
        .page_valid, .rx_page, .page_sent, .tx_page);

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_done, w_done;
        @(posedge aclk);
        {aw_done, w_done} = 2'b00;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (s_axi_awready && !aw_done) begin
                s_axi_awvalid <= 1'b0;
                aw_done = 1'b1;
            end
            if (s_axi_wready && !w_done) begin
                s_axi_wvalid <= 1'b0;
                w_done = 1'b1;
            end
        end
        while (!s_axi_bvalid) @(posedge aclk);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        rd_data = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        rd(a);
        chk(what, rd_data, exp);
    endtask : rdchk

    task automatic t_reset();
        rdchk(`OFF_EXPANSION, 32'h4, "expansion reset");
        rdchk(`OFF_NP_TRANSMIT, 32'h2001, "np reset");
        rd(8'h40);
        chk("unmapped read resp", resp, 2'h2);
        wr(8'h40, 32'h1);
        chk("unmapped write resp", resp, 2'h2);
        $display("test reset done");
    endtask : t_reset

    task automatic t_np_fields();
        wr(`OFF_NP_TRANSMIT, 32'hffffffff);
        rdchk(`OFF_NP_TRANSMIT, 32'hb7ff, "np all ones");
        @(negedge aclk);
        chk("tx word", tx_page, 16'hb7ff);
        wr(`OFF_NP_TRANSMIT, 32'h0);
        rdchk(`OFF_NP_TRANSMIT, 32'h0, "np all zero");
        s_axi_wstrb <= 4'h2;
        wr(`OFF_NP_TRANSMIT, 32'hffff);
        rdchk(`OFF_NP_TRANSMIT, 32'hb700, "np high byte");
        s_axi_wstrb <= 4'hf;
        wr(`OFF_NP_TRANSMIT, 32'hb7ff);
        $display("test np fields done");
    endtask : t_np_fields

    task automatic t_legacy();
        wr(`OFF_CONFIG, 32'h1);
        wr(`OFF_NP_TRANSMIT, 32'h0);
        rdchk(`OFF_NP_TRANSMIT, 32'hb7ff, "np write ignored");
        rdchk(`OFF_EXPANSION, 32'h0, "np able off");
        wr(`OFF_CONFIG, 32'h0);
        rdchk(`OFF_EXPANSION, 32'h4, "np able back");
        $display("test legacy done");
    endtask : t_legacy

    task automatic t_par_fault();
        lp_u.set_links(1'b1, 1'b1, 1'b0);
        rdchk(`OFF_EXPANSION, 32'h14, "both links fault");
        rdchk(`OFF_EXPANSION, 32'h4, "fault self clear");
        rdchk(`OFF_EVENT_STATUS, 32'h1, "fault event");
        chk("irq masked", irq, 1'b0);
        wr(`OFF_EVENT_MASK, 32'h1);
        @(negedge aclk);
        chk("irq raised", irq, 1'b1);
        wr(`OFF_EVENT_STATUS, 32'h1);
        @(negedge aclk);
        chk("irq cleared", irq, 1'b0);
        lp_u.set_links(1'b0, 1'b0, 1'b0);
        lp_u.set_links(1'b0, 1'b0, 1'b1);
        rdchk(`OFF_EXPANSION, 32'h14, "lost link fault");
        lp_u.set_links(1'b0, 1'b0, 1'b0);
        wr(`OFF_EVENT_STATUS, 32'h1);
        wr(`OFF_EVENT_MASK, 32'h0);
        $display("test parallel fault done");
    endtask : t_par_fault

    task automatic t_pages();
        wr(`OFF_CONFIG, 32'h2);
        wr(`OFF_NP_TRANSMIT, 32'h8005);
        lp_u.set_an(1'b1);
        rdchk(`OFF_EXPANSION, 32'h5, "partner an able");
        lp_u.give_page(16'h8001, 0);
        rdchk(`OFF_EXPANSION, 32'hf, "base page");
        rdchk(`OFF_EXPANSION, 32'hd, "page rcvd clear");
        rdchk(`OFF_PARTNER_PAGE, 32'h8001, "base word");
        rdchk(`OFF_NP_TRANSMIT, 32'hc005, "ack set");
        @(negedge aclk);
        chk("exchange on", np_exchange_en, 1'b1);
        // next page with its own bit 15 clear must not touch partner ability
        lp_u.give_page(16'h0002, 3);
        rdchk(`OFF_EXPANSION, 32'hf, "next page");
        rdchk(`OFF_PARTNER_PAGE, 32'h2, "next word");
        lp_u.take_page();
        rdchk(`OFF_NP_TRANSMIT, 32'hc805, "toggle one");
        @(negedge aclk);
        chk("tx word toggled", tx_page, 16'hc805);
        lp_u.take_page();
        rdchk(`OFF_NP_TRANSMIT, 32'hc005, "toggle back");
        chk("sent word", lp_u.last_sent, 32'hc805);
        rdchk(`OFF_EVENT_STATUS, 32'h6, "page events");
        lp_u.set_an(1'b0);
        rdchk(`OFF_EXPANSION, 32'h4, "partner gone");
        rdchk(`OFF_NP_TRANSMIT, 32'h8005, "ack idle");
        chk("exchange off", np_exchange_en, 1'b0);
        wr(`OFF_CONFIG, 32'h0);
        wr(`OFF_EVENT_STATUS, 32'h7);
        $display("test pages done");
    endtask : t_pages

    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        s_axi_awaddr = 8'h0;
        s_axi_araddr = 8'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_np_fields();
        t_legacy();
        t_par_fault();
        t_pages();
        end_of_test();
    end

    // whole run is well under two thousand cycles
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        $display("watchdog expired");
        end_of_test();
    end
endmodule : autoneg_expansion_nextpage_regs_tb

// file: testbench/link_partner_model.sv
// behavioural link partner driving the link-side status lines
module link_partner_model (
    input  wire logic        aclk,
    output logic             link10_ok,
    output logic             link100_ok,
    output logic             link_lost,
    output logic             partner_an_able,
    output logic             page_valid,
    output logic [15:0]      rx_page,
    output logic             page_sent,
    input  wire logic [15:0] tx_page
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] last_sent;
    initial begin
        {link10_ok, link100_ok, link_lost, partner_an_able, page_valid, page_sent} = 6'h0;
        rx_page = 16'hffff;
        last_sent = 16'h0;
    end
    // spacing covers the two-flop sync plus register update
    task automatic hold(input int n);
        repeat (n) @(posedge aclk);
    endtask : hold
    task automatic set_links(input logic l10, input logic l100, input logic lost);
        @(posedge aclk);
        link10_ok <= l10;
        link100_ok <= l100;
        link_lost <= lost;
        hold(4);
    endtask : set_links
    task automatic set_an(input logic on);
        @(posedge aclk);
        partner_an_able <= on;
        hold(4);
    endtask : set_an
    // slow adds setup and width; word is scrambled once released
    task automatic give_page(input logic [15:0] p, input int slow);
        @(posedge aclk);
        rx_page <= p;
        hold(1 + slow);
        page_valid <= 1'b1;
        hold(4 + slow);
        page_valid <= 1'b0;
        hold(1);
        rx_page <= ~p;
        hold(4);
    endtask : give_page
    task automatic take_page();
        @(posedge aclk);
        page_sent <= 1'b1;
        last_sent <= tx_page;
        hold(4);
        page_sent <= 1'b0;
        hold(4);
    endtask : take_page
endmodule : link_partner_model
